/* logic/usrt_pkg.sv */
// Types shared by the serial port.
package usrt_pkg;
    typedef enum logic [1:0] {
        USRT_IDLE,
        USRT_SHIFT,
        USRT_STOP
    } usrt_state_t;
    typedef struct packed {
        logic       txd;
        logic       txd_en;
        logic       sync_clock_pin;
        logic       xck_en;
    } usrt_pins_t;
endpackage

/* logic/usrt_regs.svh */
// Register offsets, field positions, reset values and timing counts of the serial port.
`ifndef USRT_REGS_SVH
`define USRT_REGS_SVH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define USRT_OFS_DATA    12'h000
`define USRT_OFS_CSA     12'h004
`define USRT_OFS_CB      12'h008
`define USRT_OFS_CC      12'h00C
`define USRT_OFS_BAUD    12'h010
// ****************************************************************
// Field positions
// ****************************************************************
`define USRT_CSA_DSPEED  1
`define USRT_CSA_UDRE    5
`define USRT_CSA_TXC     6
`define USRT_CSA_RXC     7
`define USRT_CB_TX9      0
`define USRT_CB_RX9      1
`define USRT_CB_TRANSMITTER_ENABLE     3
`define USRT_CB_RXEN     4
`define USRT_CB_UDRIE    5
`define USRT_CB_TXCIE    6
`define USRT_CC_POL      0
`define USRT_CC_SZ_LO    1
`define USRT_CC_STOP     3
`define USRT_CC_PODD     4
`define USRT_CC_PEN      5
`define USRT_CC_SYNC     6
`define USRT_CC_SZ_HI    7
// ****************************************************************
// Reset values and timing
// ****************************************************************
`define USRT_CC_RESET    8'h06
`define USRT_OVS_NORMAL  5'h10
`define USRT_OVS_DOUBLE  5'h08
`define USRT_SZ_NINE     3'h7
`endif

/* logic/usrt_top.sv */
// Serial transmitter and receiver front end with an APB register slave.
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/10ps
`include "usrt_regs.svh"
module usrt_top
    import usrt_pkg::*;
#(
    parameter int BAUD_W = 12
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rxd_in,
    input  wire logic        xck_in,
    output usrt_pins_t       pins,
    output logic             rx_pin_claim,
    output logic             udre_irq,
    output logic             txc_irq,
    output logic             rxc_irq,
    input  wire logic        txc_irq_ack
);
    // ****************************************************************
    // Registers and internal state
    // ****************************************************************
    logic [7:0]        cb;
    logic [7:0]        cc;
    logic              dspeed;
    logic [BAUD_W-1:0] baud;
    logic [8:0]        tbuf;
    logic              tbuf_full;
    logic              txc;
    usrt_state_t       tst;
    logic [11:0]       tsh;
    logic [3:0]        tcnt;
    logic [3:0]        tlen;
    logic              transmitter_enable_act;
    logic [BAUD_W-1:0] bdiv;
    logic [4:0]        ovs;
    logic              btick;
    logic              xck_s1;
    logic              xck_s2;
    logic              xck_d;
    logic              rxd_s1;
    logic              rxd_s2;
    usrt_state_t       rst;
    logic [9:0]        rsh;
    logic [3:0]        rcnt;
    logic [4:0]        rovs;
    logic [8:0]        rbuf;
    logic              rxc;
    logic              wr;
    logic              rd;
    logic [2:0]        csz;
    logic              sync_mode;
    logic              xck_rise;
    logic              xck_fall;
    logic              tx_edge;
    logic              rx_edge;
    logic              tx_load;
    logic              tx_shift;
    logic [4:0]        rate;

    // Number of data bits for a size code; codes 4 to 6 fall back to eight.
    function automatic logic [3:0] dbits(input logic [2:0] code);
        case (code)
            3'h0: dbits = 4'h5;
            3'h1: dbits = 4'h6;
            3'h2: dbits = 4'h7;
            3'h7: dbits = 4'h9;
            default: dbits = 4'h8;
        endcase
    endfunction

    // Masks a character to its size; bits above the size read as zero.
    function automatic logic [8:0] cmask(input logic [8:0] d, input logic [2:0] code);
        logic [8:0] m;
        m = 9'h1FF >> (4'h9 - dbits(code));
        cmask = d & m;
    endfunction

    // ****************************************************************
    // Decode and clocking
    // ****************************************************************
    assign wr        = psel && penable && pwrite;
    assign rd        = psel && penable && !pwrite;
    assign csz       = {cc[`USRT_CC_SZ_HI], cc[`USRT_CC_SZ_LO+1], cc[`USRT_CC_SZ_LO]};
    assign sync_mode = cc[`USRT_CC_SYNC];
    assign xck_rise  = xck_s2 && !xck_d;
    assign xck_fall  = !xck_s2 && xck_d;
    // Polarity picks which synchronised edge shifts and which samples.
    assign tx_edge   = cc[`USRT_CC_POL] ? xck_fall : xck_rise;
    assign rx_edge   = cc[`USRT_CC_POL] ? xck_rise : xck_fall;
    assign rate      = dspeed ? `USRT_OVS_DOUBLE : `USRT_OVS_NORMAL;
    assign tx_shift  = (tst == USRT_SHIFT) &&
                       (sync_mode ? tx_edge : (btick && tcnt == 4'(rate - 5'h1)));
    // Reloading at the last shift keeps queued frames back to back, with no idle gap.
    assign tx_load   = tbuf_full && transmitter_enable_act &&
                       (tst == USRT_IDLE || (tx_shift && tlen == 4'h0));

    // Pin synchronisers; the first stage feeds only the second.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xck_s1 <= 1'b0;
            xck_s2 <= 1'b0;
            xck_d  <= 1'b0;
            rxd_s1 <= 1'b1;
            rxd_s2 <= 1'b1;
        end else begin
            xck_s1 <= xck_in;
            xck_s2 <= xck_s1;
            xck_d  <= xck_s2;
            rxd_s1 <= rxd_in;
            rxd_s2 <= rxd_s1;
        end
    end

    // Baud divider gives btick once per oversample period.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bdiv  <= '0;
            btick <= 1'b0;
        end else if (bdiv == '0) begin
            bdiv  <= baud;
            btick <= 1'b1;
        end else begin
            bdiv  <= bdiv - 1'b1;
            btick <= 1'b0;
        end
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cb     <= 8'h00;
            cc     <= `USRT_CC_RESET;
            dspeed <= 1'b0;
            baud   <= '0;
        end else if (wr) begin
            if (paddr == `USRT_OFS_CB)
                cb <= {pwdata[7:2], 1'b0, pwdata[0]};
            if (paddr == `USRT_OFS_CC)
                cc <= pwdata[7:0];
            if (paddr == `USRT_OFS_CSA)
                dspeed <= pwdata[`USRT_CSA_DSPEED];
            if (paddr == `USRT_OFS_BAUD)
                baud <= pwdata[BAUD_W-1:0];
        end
    end

    // Transmit buffer; the ninth bit is taken when the data register is written.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tbuf      <= 9'h000;
            tbuf_full <= 1'b0;
        end else if (wr && paddr == `USRT_OFS_DATA) begin
            tbuf      <= {cb[`USRT_CB_TX9], pwdata[7:0]};
            tbuf_full <= 1'b1;
        end else if (tx_load) begin
            tbuf_full <= 1'b0;
        end
    end

    // Transmitter stays owned until both buffer and shifter are empty.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            transmitter_enable_act <= 1'b0;
        else if (cb[`USRT_CB_TRANSMITTER_ENABLE])
            transmitter_enable_act <= 1'b1;
        else if (!tbuf_full && tst == USRT_IDLE)
            transmitter_enable_act <= 1'b0;
    end

    // ****************************************************************
    // Transmit shifter
    // ****************************************************************
    // A frame is start, data LSB first, parity, stops; tlen counts bits.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tst  <= USRT_IDLE;
            tsh  <= 12'hFFF;
            tcnt <= 4'h0;
            tlen <= 4'h0;
        end else if (tx_load) begin
            // Cells above the size fill with ones, so upper bits never escape.
            tsh  <= {2'b11, cmask(tbuf, csz) | ~cmask(9'h1FF, csz), 1'b0};
            if (cc[`USRT_CC_PEN])
                tsh[dbits(csz)+1] <= ^cmask(tbuf, csz) ^ cc[`USRT_CC_PODD];
            tlen <= 4'(dbits(csz) + (cc[`USRT_CC_PEN] ? 4'h1 : 4'h0)
                    + (cc[`USRT_CC_STOP] ? 4'h2 : 4'h1));
            tcnt <= 4'h0;
            tst  <= USRT_SHIFT;
        end else begin
            unique case (tst)
                USRT_IDLE: tst <= USRT_IDLE;
                USRT_SHIFT: begin
                    // One bit per oversample count or per shifting clock edge.
                    if (tx_shift) begin
                        tsh  <= {1'b1, tsh[11:1]};
                        tlen <= tlen - 4'h1;
                        if (tlen == 4'h0)
                            tst <= USRT_STOP;
                    end
                    if (btick && !sync_mode)
                        tcnt <= (tcnt == 4'(rate - 5'h1)) ? 4'h0 : tcnt + 4'h1;
                end
                USRT_STOP: begin
                    tst <= USRT_IDLE;
                end
                default: tst <= USRT_IDLE;
            endcase
        end
    end

    // Complete flag: set wins over any clear in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            txc <= 1'b0;
        else if (tst == USRT_STOP && !tbuf_full)
            txc <= 1'b1;
        else if (txc_irq_ack || (wr && paddr == `USRT_OFS_CSA && pwdata[`USRT_CSA_TXC]))
            txc <= 1'b0;
    end

    // ****************************************************************
    // Receiver
    // ****************************************************************
    // Start is checked mid-bit, later bits one bit time apart; first stop ends.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst  <= USRT_IDLE;
            rsh  <= 10'h000;
            rcnt <= 4'h0;
            rovs <= 5'h00;
        end else if (!cb[`USRT_CB_RXEN]) begin
            rst <= USRT_IDLE;
        end else begin
            unique case (rst)
                USRT_IDLE: begin
                    rovs <= 5'h00;
                    rcnt <= 4'(dbits(csz) + (cc[`USRT_CC_PEN] ? 4'h1 : 4'h0));
                    if (!rxd_s2)
                        rst <= USRT_SHIFT;
                end
                USRT_SHIFT: begin
                    if (sync_mode ? rx_edge : (btick && rovs == 5'(rate - 5'h1))) begin
                        rovs <= 5'h00;
                        rsh  <= {rxd_s2, rsh[9:1]};
                        rcnt <= rcnt - 4'h1;
                        // Only the first stop is taken; the second is line idle.
                        if (rcnt == 4'h0)
                            rst <= USRT_STOP;
                    end else if (btick) begin
                        rovs <= rovs + 5'h01;
                        if (!sync_mode && rovs == 5'(rate >> 1) && rcnt ==
                            4'(dbits(csz) + (cc[`USRT_CC_PEN] ? 4'h1 : 4'h0)) && rxd_s2)
                            rst <= USRT_IDLE;
                    end
                end
                USRT_STOP: rst <= USRT_IDLE;
                default:   rst <= USRT_IDLE;
            endcase
        end
    end

    // Receive buffer and complete flag; load wins over a same-cycle read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rbuf <= 9'h000;
            rxc  <= 1'b0;
        end else if (!cb[`USRT_CB_RXEN]) begin
            rxc <= 1'b0;
        end else if (rst == USRT_STOP) begin
            rbuf <= cmask(9'(rsh >> (4'hA - dbits(csz) - (cc[`USRT_CC_PEN] ? 4'h2 : 4'h1))),
                          csz);
            rxc  <= 1'b1;
        end else if (rd && paddr == `USRT_OFS_DATA) begin
            rxc <= 1'b0;
        end
    end

    // ****************************************************************
    // Pins, requests and APB read path
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins         <= '{txd: 1'b1, txd_en: 1'b0, sync_clock_pin: 1'b0, xck_en: 1'b0};
            rx_pin_claim <= 1'b0;
            udre_irq     <= 1'b0;
            txc_irq      <= 1'b0;
            rxc_irq      <= 1'b0;
        end else begin
            pins.txd     <= (tst == USRT_SHIFT) ? tsh[0] : 1'b1;
            pins.txd_en  <= transmitter_enable_act;
            pins.sync_clock_pin     <= 1'b0;
            pins.xck_en  <= 1'b0;
            rx_pin_claim <= cb[`USRT_CB_RXEN];
            udre_irq     <= !tbuf_full && cb[`USRT_CB_UDRIE];
            txc_irq      <= txc && cb[`USRT_CB_TXCIE];
            rxc_irq      <= rxc;
        end
    end

    // Zero-wait slave; unmapped offsets read zero, and those above the baud register flag an error.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && paddr > `USRT_OFS_BAUD;
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    `USRT_OFS_DATA: prdata <= {24'h000000, rbuf[7:0]};
                    `USRT_OFS_CSA:  prdata <= {24'h000000, rxc, txc, !tbuf_full, 3'h0,
                                               dspeed, 1'b0};
                    `USRT_OFS_CB:   prdata <= {24'h000000, cb[7:2], rbuf[8], cb[0]};
                    `USRT_OFS_CC:   prdata <= {24'h000000, cc};
                    `USRT_OFS_BAUD: prdata <= 32'(baud);
                    default:        prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

/* tb/usrt_remote_model.sv */
// Remote serial device: frame monitor on the transmit line, frame sender on receive.
`timescale 1ns/10ps
module usrt_remote_model (
    input  wire logic pclk,
    input  wire logic txd,
    input  wire logic txd_en,
    output logic      rxd
);
    int         nb = 8;
    logic       pen = 1'b0;
    logic       odd = 1'b0;
    int         bt = 16;
    int         cyc = 0;
    logic [9:0] frames[$];
    int         starts[$];
    // Free cycle count, used to time frame starts.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
    end
    // The line idles high between frames.
    initial begin
        rxd = 1'b1;
    end
    // Samples mid-cell; parity and first stop fold into the ok bit.
    always begin : monitor
        logic [8:0] v;
        logic       ok;
        int         t0;
        @(negedge txd iff txd_en === 1'b1);
        t0 = cyc;
        v = '0;
        repeat (bt / 2) @(posedge pclk);
        ok = !txd;
        for (int i = 0; i < nb; i++) begin
            repeat (bt) @(posedge pclk);
            v[i] = txd;
        end
        if (pen) begin
            repeat (bt) @(posedge pclk);
            ok &= (txd == (^v ^ odd));
        end
        repeat (bt) @(posedge pclk);
        ok &= txd;
        frames.push_back({ok, v});
        starts.push_back(t0);
    end
    // Sends one frame after gap idle cycles, LSB first, one stop.
    task automatic send(input logic [8:0] v, input int gap);
        logic p;
        p = odd;
        repeat (gap) @(posedge pclk);
        rxd <= 1'b0;
        repeat (bt) @(posedge pclk);
        for (int i = 0; i < nb; i++) begin
            rxd <= v[i];
            p ^= v[i];
            repeat (bt) @(posedge pclk);
        end
        if (pen) begin
            rxd <= p;
            repeat (bt) @(posedge pclk);
        end
        rxd <= 1'b1;
        repeat (bt) @(posedge pclk);
    endtask
endmodule

/* tb/usrt_top_sva.sv */
// Concurrent checks on the serial port's bus answer and pin behaviour.
`timescale 1ns/10ps
`include "usrt_regs.svh"
module usrt_top_sva
    import usrt_pkg::*;
#(
    parameter int BAUD_W = 12
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rxd_in,
    input wire logic        xck_in,
    input usrt_pins_t       pins,
    input wire logic        rx_pin_claim,
    input wire logic        udre_irq,
    input wire logic        txc_irq,
    input wire logic        rxc_irq,
    input wire logic        txc_irq_ack
);
    // ********
    // Checks
    // ********
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A completed access, and a completed write to control B.
    sequence s_acc;
        psel && penable && pready;
    endsequence
    sequence s_cb_wr;
        s_acc ##0 (pwrite && paddr == `USRT_OFS_CB);
    endsequence
    a_bus_answer: assert property (psel && !penable |=> pready)
        else $error("no answer one cycle after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held beyond one cycle");
    a_bad_address: assert property (s_acc |-> pslverr == (paddr > 12'h010))
        else $error("error response does not match address");
    a_rx_claim: assert property (
        s_cb_wr |-> ##2 rx_pin_claim == $past(pwdata[`USRT_CB_RXEN], 2))
        else $error("receive pin claim differs from enable");
    a_tx_claim: assert property (
        s_cb_wr ##0 pwdata[`USRT_CB_TRANSMITTER_ENABLE] |-> ##3 pins.txd_en)
        else $error("transmit pin not taken over");
    a_idle_high: assert property ($rose(pins.txd_en) |-> pins.txd)
        else $error("transmit line not idle high");
    // The start bit lasts at least the shortest asynchronous bit time, eight clocks.
    a_start_len: assert property (
        $fell(pins.txd) && pins.txd_en |-> !pins.txd [*8])
        else $error("start bit too short");
    a_txc_rise: assert property ($rose(txc_irq) |-> $past(pins.txd, 4))
        else $error("complete request without stop bit");
    a_txc_ack: assert property (txc_irq && txc_irq_ack |-> ##[1:2] !txc_irq)
        else $error("complete request not cleared by service");
endmodule
bind usrt_top usrt_top_sva #(.BAUD_W(BAUD_W)) usrt_top_sva_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd_in(rxd_in), .xck_in(xck_in),
    .pins(pins), .rx_pin_claim(rx_pin_claim), .udre_irq(udre_irq),
    .txc_irq(txc_irq), .rxc_irq(rxc_irq), .txc_irq_ack(txc_irq_ack)
);

/* tb/usrt_top_tb_top.sv */
// Self-checking bench: APB register traffic and serial frames in both directions.
`timescale 1ns/10ps
`include "usrt_regs.svh"
module usrt_top_tb_top
    import usrt_pkg::*;
;
    localparam int LIMIT = 8000;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rxd_in;
    logic        xck_in;
    usrt_pins_t  pins;
    logic        rx_pin_claim;
    logic        udre_irq;
    logic        txc_irq;
    logic        rxc_irq;
    logic        txc_irq_ack;
    int          miscompares = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          t_prev;
    int          t_cur;
    logic [31:0] rdv;
    logic        errv;
    usrt_top #(.BAUD_W(12)) usrt_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxd_in(rxd_in), .xck_in(xck_in),
        .pins(pins), .rx_pin_claim(rx_pin_claim), .udre_irq(udre_irq),
        .txc_irq(txc_irq), .rxc_irq(rxc_irq), .txc_irq_ack(txc_irq_ack)
    );
    usrt_remote_model usrt_remote_model_inst (
        .pclk(pclk), .txd(pins.txd), .txd_en(pins.txd_en), .rxd(rxd_in)
    );
    // ********
    // Clock, timeout and helpers
    // ********
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // A hang counts as a mismatch and ends the run.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (miscompares == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // One APB transfer; the request stands until pready is seen high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string n);
        apb(1'b0, a, 32'h0);
        chk(n, rdv, exp);
    endtask
    task automatic fmt(input int n, input logic p, input logic o, input int b);
        usrt_remote_model_inst.nb = n;
        usrt_remote_model_inst.pen = p;
        usrt_remote_model_inst.odd = o;
        usrt_remote_model_inst.bt = b;
    endtask
    task automatic frame(input logic [9:0] exp);
        while (usrt_remote_model_inst.frames.size() == 0) @(posedge pclk);
        t_prev = t_cur;
        t_cur = usrt_remote_model_inst.starts.pop_front();
        chk("tx frame", 32'(usrt_remote_model_inst.frames.pop_front()), 32'(exp));
    endtask
    // ********
    // Main sequence
    // ********
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, xck_in, txc_irq_ack} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(`USRT_OFS_CSA, 32'h20, "status reset");
        rd(12'h014, 32'h0, "unmapped read");
        chk("unmapped error", 32'(errv), 32'h1);
        // Eight bits, even parity; two writes queue one frame behind another.
        fmt(8, 1'b1, 1'b0, 16);
        wr(`USRT_OFS_BAUD, 32'h0);
        wr(`USRT_OFS_CC, 32'h26);
        wr(`USRT_OFS_CB, 32'h78);
        repeat (3) @(posedge pclk);
        chk("txd idle", 32'(pins.txd), 32'h1);
        chk("empty request", 32'(udre_irq), 32'h1);
        wr(`USRT_OFS_DATA, 32'hA5);
        wr(`USRT_OFS_DATA, 32'h3C);
        rd(`USRT_OFS_CSA, 32'h00, "buffer full");
        chk("empty request off", 32'(udre_irq), 32'h0);
        frame({1'b1, 9'h0A5});
        frame({1'b1, 9'h03C});
        chk("frame spacing", 32'(t_cur - t_prev), 32'd176);
        while (txc_irq !== 1'b1) @(posedge pclk);
        rd(`USRT_OFS_CSA, 32'h60, "tx done");
        wr(`USRT_OFS_CSA, 32'h40);
        rd(`USRT_OFS_CSA, 32'h20, "tx done cleared");
        wr(`USRT_OFS_CB, 32'h58);
        repeat (3) @(posedge pclk);
        chk("empty masked", 32'(udre_irq), 32'h0);
        // Five bits, odd parity, double speed; upper data bits dropped.
        fmt(5, 1'b1, 1'b1, 8);
        wr(`USRT_OFS_CC, 32'h30);
        wr(`USRT_OFS_CSA, 32'h02);
        wr(`USRT_OFS_DATA, 32'hFF);
        frame({1'b1, 9'h01F});
        while (txc_irq !== 1'b1) @(posedge pclk);
        txc_irq_ack <= 1'b1;
        @(posedge pclk);
        txc_irq_ack <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("complete serviced", 32'(txc_irq), 32'h0);
        usrt_remote_model_inst.send(9'h1EA, 5);
        while (rxc_irq !== 1'b1) @(posedge pclk);
        rd(`USRT_OFS_DATA, 32'h0A, "rx five");
        // Nine bits, two stops; the ninth bit changes after its frame is queued.
        fmt(9, 1'b0, 1'b0, 16);
        wr(`USRT_OFS_CSA, 32'h00);
        wr(`USRT_OFS_CC, 32'h8E);
        wr(`USRT_OFS_DATA, 32'h33);
        wr(`USRT_OFS_CB, 32'h59);
        wr(`USRT_OFS_DATA, 32'h5A);
        wr(`USRT_OFS_CB, 32'h58);
        frame({1'b1, 9'h033});
        frame({1'b1, 9'h15A});
        usrt_remote_model_inst.send(9'h1C3, 0);
        repeat (3) @(posedge pclk);
        chk("rx at first stop", 32'(rxc_irq), 32'h1);
        rd(`USRT_OFS_CB, 32'h5A, "rx ninth");
        rd(`USRT_OFS_DATA, 32'hC3, "rx nine");
        // Synchronous slave: bits change on the synced rising edge of a 16-clock clock.
        fmt(8, 1'b0, 1'b0, 16);
        wr(`USRT_OFS_CC, 32'h46);
        wr(`USRT_OFS_DATA, 32'h96);
        fork
            repeat (20) begin
                repeat (8) @(posedge pclk);
                xck_in <= ~xck_in;
            end
        join_none
        frame({1'b1, 9'h096});
        chk("clock pin input", 32'(pins.xck_en), 32'h0);
        repeat (40) @(posedge pclk);
        fmt(9, 1'b0, 1'b0, 16);
        wr(`USRT_OFS_CC, 32'h8E);
        // Disable with a frame pending: the pin stays claimed until it is out.
        wr(`USRT_OFS_DATA, 32'h77);
        wr(`USRT_OFS_CB, 32'h00);
        chk("pin held", 32'(pins.txd_en), 32'h1);
        frame({1'b1, 9'h077});
        repeat (40) @(posedge pclk);
        chk("pin freed", 32'(pins.txd_en), 32'h0);
        report_and_stop();
    end
endmodule
